// >>> verilog/timer16_pkg.sv
// Package with register map, field positions and reset values for the timer
package timer16_pkg;
  // Byte addresses of the word-aligned registers
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CAP1_HIGH = 8'h04;
  localparam logic [7:0] ADDR_CAP1_LOW = 8'h08;
  localparam logic [7:0] ADDR_CMP1_HIGH = 8'h0c;
  localparam logic [7:0] ADDR_CMP1_LOW = 8'h10;
  localparam logic [7:0] ADDR_CMP2_HIGH = 8'h14;
  localparam logic [7:0] ADDR_CMP2_LOW = 8'h18;
  localparam logic [7:0] ADDR_CNT_HIGH = 8'h1c;
  localparam logic [7:0] ADDR_CNT_LOW = 8'h20;
  localparam logic [7:0] ADDR_ALT_HIGH = 8'h24;
  localparam logic [7:0] ADDR_ALT_LOW = 8'h28;
  localparam logic [7:0] ADDR_CAP2_HIGH = 8'h2c;
  localparam logic [7:0] ADDR_CAP2_LOW = 8'h30;
  localparam logic [7:0] ADDR_CONFIG = 8'h34;
  // Status field positions
  localparam int BIT_CAP1_FLAG = 7;
  localparam int BIT_CMP1_FLAG = 6;
  localparam int BIT_OVF_FLAG = 5;
  localparam int BIT_CAP2_FLAG = 4;
  localparam int BIT_CMP2_FLAG = 3;
  localparam int BIT_DISABLE = 2;
  // Config field positions
  localparam int BIT_CAP_IE = 7;
  localparam int BIT_CMP_IE = 6;
  localparam int BIT_OVF_IE = 5;
  localparam int BIT_PWM = 4;
  localparam int BIT_EDGE2 = 3;
  localparam int BIT_EDGE1 = 2;
  localparam int BIT_LEVEL2 = 1;
  localparam int BIT_LEVEL1 = 0;
  // Reset values
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'hfffc;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  // Counter advances once every PRESCALE_LAST plus one (four) pclk cycles
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
endpackage

// >>> verilog/timer16_status_capture_regs.sv
// Status, capture, compare and counter registers of a 16-bit timer
`timescale 1ns/1ps
module timer16_status_capture_regs
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer pins
  input wire logic capture_one_pin,
  input wire logic capture_two_pin,
  output logic compare_one_pin,
  output logic compare_two_pin,
  output logic compare_one_oe,
  output logic compare_two_oe,
  // Interrupt request
  output logic timer_irq
);
  import timer16_pkg::*;

  logic capture_one_flag_q;
  logic compare_one_flag_q;
  logic overflow_flag_q;
  logic capture_two_flag_q;
  logic compare_two_flag_q;
  logic timer_disable_bit_q;
  logic [7:0] status_word;
  logic [7:0] config_q;
  logic [15:0] count_q;
  logic [1:0] presc_q;
  logic [15:0] cap1_q;
  logic [15:0] cap2_q;
  logic [15:0] cmp1_q;
  logic [15:0] cmp2_q;
  logic armed_q;
  logic armed_rd_q;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic level1_q;
  logic level2_q;

  logic access;
  logic wr;
  logic rd;
  logic hit_status;
  logic tick;
  logic cnt_reset;
  logic cap1_evt;
  logic cap2_evt;
  logic cmp1_evt;
  logic cmp2_evt;
  logic ovf_evt;
  logic pwm_evt;
  logic disabled;
  logic [7:0] rdata;
  logic known;
  logic clr_cap1;
  logic clr_cmp1;
  logic clr_ovf;
  logic clr_cap2;
  logic clr_cmp2;

  // Address match of a completing access
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // Second step of a flag clear: an armed access to the low byte
  function automatic logic clear_hit(input logic acc, input logic arm,
                                     input logic [7:0] a,
                                     input logic [7:0] r);
    clear_hit = acc & arm & (a == r);
  endfunction

  // Single-cycle access: every access completes in its access phase
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign hit_status = access & hit(paddr, ADDR_STATUS);
  assign disabled = timer_disable_bit_q;

  // Only a status read arms the capture and compare flag clears
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      armed_rd_q <= 1'b0;
    else if (rd & hit(paddr, ADDR_STATUS))
      armed_rd_q <= 1'b1;
    else if (access)
      armed_rd_q <= 1'b0;
  end

  // Any status access, read or write, arms the overflow clear
  // A write counts too, so freezing then reading the counter clears it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      armed_q <= 1'b0;
    else if (hit_status)
      armed_q <= 1'b1;
    else if (access)
      armed_q <= 1'b0;
  end

  // Pin synchronisers; bit 0 is only read by bit 1
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {sync1_q[1:0], capture_one_pin};
      sync2_q <= {sync2_q[1:0], capture_two_pin};
    end
  end

  // Edge selection on synchronised capture inputs
  assign cap1_evt = config_q[BIT_EDGE1] ? (sync1_q[1] & ~sync1_q[2])
                                        : (~sync1_q[1] & sync1_q[2]);
  assign cap2_evt = config_q[BIT_EDGE2] ? (sync2_q[1] & ~sync2_q[2])
                                        : (~sync2_q[1] & sync2_q[2]);

  // Counter events only fire on a live prescaler tick
  assign tick = ~disabled & (presc_q == PRESCALE_LAST);
  assign cmp1_evt = tick & (count_q[15:8] == cmp1_q[15:8]) &
                    (count_q[7:0] == cmp1_q[7:0]);
  assign cmp2_evt = tick & (count_q[15:8] == cmp2_q[15:8]) &
                    (count_q[7:0] == cmp2_q[7:0]);
  assign pwm_evt = cmp2_evt & config_q[BIT_PWM];
  assign ovf_evt = tick & (count_q == COUNT_MAX);

  // Either counter low byte write restarts counting, even when disabled
  assign cnt_reset = wr & (hit(paddr, ADDR_CNT_LOW) |
                           hit(paddr, ADDR_ALT_LOW));

  // Prescaler and free-running counter, frozen by the disable bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      presc_q <= 2'h0;
      count_q <= COUNT_RESET;
    end
    else if (cnt_reset)
    begin
      presc_q <= 2'h0;
      count_q <= COUNT_RESET;
    end
    else if (!disabled)
    begin
      presc_q <= presc_q + 2'h1;
      if (tick)
        count_q <= count_q + 16'h0001;
    end
  end

  // Capture latches copy the live counter on each event
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap1_q <= VALUE_RESET;
      cap2_q <= VALUE_RESET;
    end
    else
    begin
      if (cap1_evt)
        cap1_q <= count_q;
      if (cap2_evt)
        cap2_q <= count_q;
    end
  end

  // Compare values and configuration written by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp1_q <= VALUE_RESET;
      cmp2_q <= VALUE_RESET;
      config_q <= CONFIG_RESET;
    end
    else if (wr)
    begin
      if (hit(paddr, ADDR_CMP1_HIGH))
        cmp1_q[15:8] <= pwdata[7:0];
      if (hit(paddr, ADDR_CMP1_LOW))
        cmp1_q[7:0] <= pwdata[7:0];
      if (hit(paddr, ADDR_CMP2_HIGH))
        cmp2_q[15:8] <= pwdata[7:0];
      if (hit(paddr, ADDR_CMP2_LOW))
        cmp2_q[7:0] <= pwdata[7:0];
      if (hit(paddr, ADDR_CONFIG))
        config_q <= pwdata[7:0];
    end
  end

  // Clear strobes; the alternate counter view never clears overflow
  assign clr_cap1 = clear_hit(access, armed_rd_q, paddr, ADDR_CAP1_LOW);
  assign clr_cmp1 = clear_hit(access, armed_rd_q, paddr, ADDR_CMP1_LOW);
  assign clr_ovf = clear_hit(access, armed_q, paddr, ADDR_CNT_LOW);
  assign clr_cap2 = clear_hit(access, armed_rd_q, paddr, ADDR_CAP2_LOW);
  assign clr_cmp2 = clear_hit(access, armed_rd_q, paddr, ADDR_CMP2_LOW);

  // Capture one flag; the set wins so a same-cycle event is not lost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      capture_one_flag_q <= 1'b0;
    else if (cap1_evt | pwm_evt)
      capture_one_flag_q <= 1'b1;
    else if (clr_cap1)
      capture_one_flag_q <= 1'b0;
  end

  // Compare one flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      compare_one_flag_q <= 1'b0;
    else if (cmp1_evt)
      compare_one_flag_q <= 1'b1;
    else if (clr_cmp1)
      compare_one_flag_q <= 1'b0;
  end

  // Overflow flag; only the main counter low byte completes its clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overflow_flag_q <= 1'b0;
    else if (ovf_evt)
      overflow_flag_q <= 1'b1;
    else if (clr_ovf)
      overflow_flag_q <= 1'b0;
  end

  // Capture two flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      capture_two_flag_q <= 1'b0;
    else if (cap2_evt)
      capture_two_flag_q <= 1'b1;
    else if (clr_cap2)
      capture_two_flag_q <= 1'b0;
  end

  // Compare two flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      compare_two_flag_q <= 1'b0;
    else if (cmp2_evt)
      compare_two_flag_q <= 1'b1;
    else if (clr_cmp2)
      compare_two_flag_q <= 1'b0;
  end

  // Disable bit is the only software-writable status bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_disable_bit_q <= 1'b0;
    else if (wr & hit(paddr, ADDR_STATUS))
      timer_disable_bit_q <= pwdata[BIT_DISABLE];
  end

  // Status word as software sees it; bits 1:0 always read zero
  always_comb
  begin
    status_word = 8'h00;
    status_word[BIT_CAP1_FLAG] = capture_one_flag_q;
    status_word[BIT_CMP1_FLAG] = compare_one_flag_q;
    status_word[BIT_OVF_FLAG] = overflow_flag_q;
    status_word[BIT_CAP2_FLAG] = capture_two_flag_q;
    status_word[BIT_CMP2_FLAG] = compare_two_flag_q;
    status_word[BIT_DISABLE] = timer_disable_bit_q;
  end

  // Output compare levels follow the configured level on a match
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level1_q <= 1'b0;
      level2_q <= 1'b0;
    end
    else
    begin
      if (cmp1_evt)
        level1_q <= config_q[BIT_LEVEL1];
      if (cmp2_evt)
        level2_q <= config_q[BIT_LEVEL2];
    end
  end

  // Pins registered; the disable bit releases both drivers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      compare_one_pin <= 1'b0;
      compare_two_pin <= 1'b0;
      compare_one_oe <= 1'b0;
      compare_two_oe <= 1'b0;
    end
    else
    begin
      compare_one_pin <= level1_q & ~disabled;
      compare_two_pin <= level2_q & ~disabled;
      compare_one_oe <= ~disabled;
      compare_two_oe <= ~disabled;
    end
  end

  // Interrupt request, registered so the output is a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_irq <= 1'b0;
    else
      timer_irq <= (config_q[BIT_CAP_IE] & (capture_one_flag_q |
                    capture_two_flag_q)) |
                   (config_q[BIT_CMP_IE] & (compare_one_flag_q |
                    compare_two_flag_q)) |
                   (config_q[BIT_OVF_IE] & overflow_flag_q);
  end

  // Read multiplexer; unknown addresses read zero and error
  always_comb
  begin
    rdata = 8'h00;
    known = 1'b1;
    case (paddr)
      ADDR_STATUS: rdata = status_word;
      ADDR_CAP1_HIGH: rdata = cap1_q[15:8];
      ADDR_CAP1_LOW: rdata = cap1_q[7:0];
      ADDR_CMP1_HIGH: rdata = cmp1_q[15:8];
      ADDR_CMP1_LOW: rdata = cmp1_q[7:0];
      ADDR_CMP2_HIGH: rdata = cmp2_q[15:8];
      ADDR_CMP2_LOW: rdata = cmp2_q[7:0];
      ADDR_CNT_HIGH: rdata = count_q[15:8];
      ADDR_CNT_LOW: rdata = count_q[7:0];
      ADDR_ALT_HIGH: rdata = count_q[15:8];
      ADDR_ALT_LOW: rdata = count_q[7:0];
      ADDR_CAP2_HIGH: rdata = cap2_q[15:8];
      ADDR_CAP2_LOW: rdata = cap2_q[7:0];
      ADDR_CONFIG: rdata = config_q;
      default: known = 1'b0;
    endcase
  end

  // APB answer: no wait cycle, pready high in the first access-phase cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~known;
      prdata <= (psel & ~penable & ~pwrite) ? {24'h000000, rdata}
                                            : 32'h0000_0000;
    end
  end

endmodule

// >>> dv/timer16_asserts.sv
// Port-level checker for the timer register block
`timescale 1ns/1ps
module timer16_asserts
  import timer16_pkg::*;
(
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic compare_one_pin,
  input wire logic compare_two_pin,
  input wire logic compare_one_oe,
  input wire logic compare_two_oe
);
  logic dis_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Shadow of the disable bit, so pin checks need no internal probe
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      dis_q <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == ADDR_STATUS)
      dis_q <= pwdata[BIT_DISABLE];

  a_ready_after_setup: assert property (
    psel && !penable |=> pready) else $error("no ready after setup");
  a_ready_once: assert property (
    pready |=> !pready) else $error("ready held too long");
  a_err_zero_data: assert property (
    pslverr |-> pready && prdata == 32'h0) else $error("bad error reply");
  a_byte_read: assert property (
    pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("wide read");
  a_status_bits: assert property (
    pready && !pwrite && paddr == ADDR_STATUS |->
      prdata[1:0] == 2'h0 && prdata[2] == dis_q) else $error("status bits");
  a_oe_off: assert property (
    dis_q && $past(dis_q) |-> !compare_one_oe && !compare_two_oe)
    else $error("output enabled while disabled");
  a_pins_low: assert property (
    dis_q && $past(dis_q) |-> !compare_one_pin && !compare_two_pin)
    else $error("compare pin high while disabled");
  a_oe_on: assert property (
    $past(presetn) && !dis_q && !$past(dis_q) |->
      compare_one_oe && compare_two_oe) else $error("output not enabled");
endmodule

// >>> dv/capture_pin_source.sv
// Model of the external drivers of the two capture pins
`timescale 1ns/1ps
module capture_pin_source
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Commands from the bench
  input wire logic fire_one,
  input wire logic fire_two,
  // Driven pins
  output logic capture_one_pin,
  output logic capture_two_pin
);
  // Each command flips the pin; a push-pull driver, so never floating
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      capture_one_pin <= 1'b0;
      capture_two_pin <= 1'b0;
    end
    else
    begin
      capture_one_pin <= capture_one_pin ^ fire_one;
      capture_two_pin <= capture_two_pin ^ fire_two;
    end
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the timer register block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  miscompares++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
  import timer16_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic fire_one = 1'b0;
  logic fire_two = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, timer_irq, ev;
  logic capture_one_pin, capture_two_pin, compare_one_pin, compare_two_pin;
  logic compare_one_oe, compare_two_oe;
  logic [7:0] rv, held;
  int miscompares = 0;
  int n_compared = 0;

  // 25 MHz clock
  initial
    forever #20 pclk = ~pclk;

  timer16_status_capture_regs dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .capture_one_pin,
    .capture_two_pin, .compare_one_pin, .compare_two_pin, .compare_one_oe,
    .compare_two_oe, .timer_irq);
  capture_pin_source pins (.pclk, .presetn, .fire_one, .fire_two,
    .capture_one_pin, .capture_two_pin);

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One APB transfer; request held until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rv = prdata[7:0];
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      miscompares++;
      results();
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK($sformatf("reg %h", a), e, rv)
  endtask

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rc(ADDR_STATUS, 8'h00);
    // Counter starts near the top: wrap, then match both zero compares
    repeat (60) @(posedge pclk);
    rc(ADDR_STATUS, 8'h68);
    apb(1'b0, ADDR_ALT_LOW, 8'h00);
    rc(ADDR_STATUS, 8'h68);
    apb(1'b0, ADDR_CNT_LOW, 8'h00);
    rc(ADDR_STATUS, 8'h48);
    apb(1'b0, ADDR_CMP1_LOW, 8'h00);
    rc(ADDR_STATUS, 8'h08);
    apb(1'b1, ADDR_CMP2_LOW, 8'h00);
    rc(ADDR_STATUS, 8'h00);
    // Freeze, then reset the counter through the main view
    apb(1'b1, ADDR_STATUS, 8'h04);
    apb(1'b0, ADDR_CNT_LOW, 8'h00);
    held = rv;
    repeat (20) @(posedge pclk);
    rc(ADDR_CNT_LOW, held);
    apb(1'b1, ADDR_CNT_LOW, 8'h00);
    rc(ADDR_CNT_HIGH, COUNT_RESET[15:8]);
    rc(ADDR_CNT_LOW, COUNT_RESET[7:0]);
    // Short run, too short to wrap, then alternate reset
    apb(1'b1, ADDR_STATUS, 8'h00);
    repeat (2) @(posedge pclk);
    apb(1'b1, ADDR_STATUS, 8'h04);
    apb(1'b1, ADDR_ALT_LOW, 8'h00);
    rc(ADDR_ALT_HIGH, COUNT_RESET[15:8]);
    rc(ADDR_ALT_LOW, COUNT_RESET[7:0]);
    apb(1'b1, ADDR_CMP1_HIGH, 8'h12);
    apb(1'b1, ADDR_CMP1_LOW, 8'h34);
    rc(ADDR_CMP1_HIGH, 8'h12);
    rc(ADDR_CMP1_LOW, 8'h34);
    // Rising edges on both capture pins while the count is frozen
    apb(1'b1, ADDR_CONFIG, 8'h0c);
    fire_one <= 1'b1;
    fire_two <= 1'b1;
    @(posedge pclk);
    fire_one <= 1'b0;
    fire_two <= 1'b0;
    repeat (6) @(posedge pclk);
    rc(ADDR_STATUS, 8'h94);
    rc(ADDR_CAP1_HIGH, COUNT_RESET[15:8]);
    rc(ADDR_CAP1_LOW, COUNT_RESET[7:0]);
    rc(ADDR_STATUS, 8'h94);
    rc(ADDR_CAP1_LOW, COUNT_RESET[7:0]);
    rc(ADDR_STATUS, 8'h14);
    rc(ADDR_CAP2_LOW, COUNT_RESET[7:0]);
    rc(ADDR_CAP2_HIGH, COUNT_RESET[15:8]);
    rc(ADDR_STATUS, 8'h04);
    // Falling edges with capture interrupts on; a status write does not arm the capture clears
    apb(1'b1, ADDR_CONFIG, 8'h80);
    fire_one <= 1'b1;
    fire_two <= 1'b1;
    @(posedge pclk);
    fire_one <= 1'b0;
    fire_two <= 1'b0;
    repeat (6) @(posedge pclk);
    rc(ADDR_STATUS, 8'h94);
    `CHK("irq set", 1'b1, timer_irq)
    apb(1'b1, ADDR_STATUS, 8'h04);
    apb(1'b0, ADDR_CAP1_LOW, 8'h00);
    rc(ADDR_STATUS, 8'h94);
    rc(ADDR_CAP1_LOW, COUNT_RESET[7:0]);
    rc(ADDR_STATUS, 8'h14);
    rc(ADDR_CAP2_LOW, COUNT_RESET[7:0]);
    rc(ADDR_STATUS, 8'h04);
    `CHK("irq clear", 1'b0, timer_irq)
    // PWM mode: the second compare match also raises capture one
    apb(1'b1, ADDR_CONFIG, 8'h10);
    apb(1'b1, ADDR_CMP2_HIGH, 8'hff);
    apb(1'b1, ADDR_CMP2_LOW, 8'hfe);
    apb(1'b1, ADDR_STATUS, 8'h00);
    repeat (40) @(posedge pclk);
    apb(1'b1, ADDR_STATUS, 8'h04);
    rc(ADDR_STATUS, 8'hac);
    apb(1'b0, 8'h38, 8'h00);
    `CHK("unmapped error", 1'b1, ev)
    results();
  end
endmodule

bind timer16_status_capture_regs timer16_asserts u_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .compare_one_pin, .compare_two_pin, .compare_one_oe, .compare_two_oe);
